// [design/sfpi_top.sv]
// Pin side of a serial NOR flash: lane shifter, hold, write protect and reset pin
// selection, plus page, sector and block geometry for the core behind it.
// Assumes the host makes spi_clk and drives select; core logic runs on ref_clk.
// Summary of operation
// - Single lane: sample serial_in on rising edge.
// - Single lane: drive lane1 on falling edge.
// - Multi-lane: sample rising, drive falling, bidirectional lanes.
// - Quad and four-wire modes need quad_enable set.
// - Quad enable turns WP, HOLD into lanes.
// - Low write protect blocks status writes.
// - Write protect ignored while quad_enable set.
// - Hold low: output floats, clock, input ignored.
// - Hold release resumes from preserved state.
// - Hold unavailable while quad_enable set.
// - Lane3 is hold or reset by select bit.
// - Quad enable disables both hold and reset.
// - 65536 pages of 256 bytes, 24-bit address.
// - Program within one page, ones to zeros.
// - Erase aligned 16, 128, 256 pages, chip.
// - 4096 sectors, 512 and 256 blocks, aligned.
// - Select high floats outputs; first select edge needed (not waited for here: cs_sync_ff resets high).
// - Clock idle level low or high accepted.
// - Hold starts, ends at hold edge or clock fall.
`timescale 1ns/1ps
`default_nettype none
module sfpi_top
   import sfpi_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic spi_clk,
   input wire logic cs_n,
   input wire logic [3:0] lane_in,
   output sfpi_pkg::sfpi_pins_out_t pins_out,
   input wire sfpi_pkg::sfpi_cfg_t cfg,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_instr,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic status_write_blocked,
   output logic hw_reset_req,
   output logic selected,
   input wire logic [SFPI_ADDR_W-1:0] geo_addr,
   input wire sfpi_pkg::sfpi_erase_t erase_kind,
   input wire logic [7:0] prog_old,
   input wire logic [7:0] prog_new,
   output sfpi_pkg::sfpi_geom_t geom,
   output logic [15:0] erase_first_page,
   output logic [16:0] erase_pages,
   output logic [7:0] prog_result
);
   import sfpi_pkg::*;

   // Index of the last clock edge of a byte for a given lane width.
   function automatic logic [2:0] sfpi_last_cnt(input sfpi_lane_t w);
      logic [2:0] r;
      r = 3'h7;
      case (w)
         SFPI_LANE_DUAL: r = 3'h3;
         SFPI_LANE_QUAD: r = 3'h1;
         default: r = 3'h7;
      endcase
      return r;
   endfunction

   // ---------------- ref_clk side: pin monitors ----------------
   logic [SFPI_SYNC_STAGES-1:0] cs_sync_ff;
   logic [SFPI_SYNC_STAGES-1:0] wp_sync_ff;
   logic [SFPI_SYNC_STAGES-1:0] l3_sync_ff;
   logic armed_ff;
   logic hwrst_ff;
   logic blocked_ff;

   // Two-flop synchronisers; only the last stage is read.
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cs_sync_ff <= '1;
         wp_sync_ff <= '1;
         l3_sync_ff <= '1;
      end
      else
      begin
         cs_sync_ff <= {cs_sync_ff[0], cs_n};
         wp_sync_ff <= {wp_sync_ff[0], lane_in[2]};
         l3_sync_ff <= {l3_sync_ff[0], lane_in[3]};
      end
   end

   // Accepting starts on the first edge after reset, as cs_sync_ff resets high whatever select does.
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         armed_ff <= 1'b0;
      else if (cs_sync_ff[1])
         armed_ff <= 1'b1;
   end

   // Lane3 is a reset pin only with quad_enable clear and the select bit set.
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         hwrst_ff <= 1'b0;
      else
         hwrst_ff <= !cfg.quad_enable && cfg.hold_reset_select && !l3_sync_ff[1];
   end

   // Write protect acts only while lane2 is not a data lane.
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         blocked_ff <= 1'b0;
      else
         blocked_ff <= !cfg.quad_enable && !wp_sync_ff[1];
   end

   assign status_write_blocked = blocked_ff;
   assign hw_reset_req = hwrst_ff;
   assign selected = armed_ff && !cs_sync_ff[1];

   // ---------------- spi_clk side: lane shifter ----------------
   // Select high or a pin reset clears the frame state; the clock may stop between frames.
   logic link_rst_n;
   assign link_rst_n = arst_n && !cs_n && !hwrst_ff;

   logic [SFPI_SYNC_STAGES-1:0] cfg_meta_ff [6];
   wire sfpi_cfg_t lcfg;
   genvar gi;
   // Configuration levels cross into the link clock; must settle before they are used.
   generate
      for (gi = 0; gi < 6; gi++)
      begin : g_cfg_sync
         always_ff @(posedge spi_clk or negedge arst_n)
         begin
            if (!arst_n)
               cfg_meta_ff[gi] <= '0;
            else
               cfg_meta_ff[gi] <= {cfg_meta_ff[gi][0], cfg[gi]};
         end
         assign lcfg[gi] = cfg_meta_ff[gi][1];
      end
   endgenerate

   logic hold_fn;
   logic hold_q_ff;
   logic hold_act;
   assign hold_fn = !lcfg.quad_enable && !lcfg.hold_reset_select;

   // While the clock is low a hold edge acts at once; otherwise it waits for the fall.
   always_ff @(negedge spi_clk or negedge link_rst_n)
   begin
      if (!link_rst_n)
         hold_q_ff <= 1'b0;
      else
         hold_q_ff <= hold_fn && !lane_in[3];
   end
   assign hold_act = spi_clk ? hold_q_ff : (hold_fn && !lane_in[3]);

   sfpi_phase_t phase_ff;
   sfpi_lane_t eff_w;
   // Quad transfers fall back to one lane unless quad_enable is set.
   always_comb
   begin
      eff_w = lcfg.lane;
      if (lcfg.lane == SFPI_LANE_QUAD && !lcfg.quad_enable)
         eff_w = SFPI_LANE_SINGLE;
      if (phase_ff == SFPI_PH_INSTR && lcfg.four_wire_instruction_mode && lcfg.quad_enable)
         eff_w = SFPI_LANE_QUAD;
   end

   logic [7:0] rx_shift_ff;
   logic [2:0] rx_cnt_ff;
   logic [7:0] rx_byte_ff;
   logic rx_byte_instr_ff;
   logic rx_tgl_ff;
   logic [7:0] rx_next;
   // Inbound bits, most significant first.
   always_comb
   begin
      case (eff_w)
         SFPI_LANE_DUAL: rx_next = {rx_shift_ff[5:0], lane_in[1:0]};
         SFPI_LANE_QUAD: rx_next = {rx_shift_ff[3:0], lane_in[3:0]};
         default: rx_next = {rx_shift_ff[6:0], lane_in[0]};
      endcase
   end

   // Rising edge sampling; a held edge leaves every counter where it was.
   always_ff @(posedge spi_clk or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         rx_shift_ff <= SFPI_BYTE_RST;
         rx_cnt_ff <= SFPI_CNT_RST;
         phase_ff <= SFPI_PH_INSTR;
      end
      else if (!(hold_fn && !lane_in[3]))
      begin
         rx_shift_ff <= rx_next;
         if (rx_cnt_ff == sfpi_last_cnt(eff_w))
         begin
            rx_cnt_ff <= SFPI_CNT_RST;
            phase_ff <= SFPI_PH_BODY;
         end
         else
            rx_cnt_ff <= rx_cnt_ff + 3'h1;
      end
   end

   // Completed bytes are published with a toggle; the byte stays put a whole byte time.
   always_ff @(posedge spi_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rx_byte_ff <= SFPI_BYTE_RST;
         rx_byte_instr_ff <= 1'b0;
         rx_tgl_ff <= 1'b0;
      end
      else if (link_rst_n && !(hold_fn && !lane_in[3]) && rx_cnt_ff == sfpi_last_cnt(eff_w))
      begin
         rx_byte_ff <= rx_next;
         rx_byte_instr_ff <= (phase_ff == SFPI_PH_INSTR);
         rx_tgl_ff <= !rx_tgl_ff;
      end
   end

   // Outbound path: the core's byte crosses by toggle and is loaded on a byte boundary.
   logic [7:0] tx_hold_ff;
   logic tx_tgl_ff;
   logic [SFPI_SYNC_STAGES-1:0] tx_tgl_sync_ff;
   logic tx_used_ff;
   logic [7:0] tx_shift_ff;
   logic [2:0] tx_cnt_ff;
   logic [3:0] out_ff;
   logic [3:0] oe_ff;
   logic [7:0] tx_src;
   logic [7:0] tx_cur;
   logic [3:0] oe_want;

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tx_hold_ff <= SFPI_BYTE_RST;
         tx_tgl_ff <= 1'b0;
      end
      else if (tx_valid)
      begin
         tx_hold_ff <= tx_data;
         tx_tgl_ff <= !tx_tgl_ff;
      end
   end

   always_ff @(negedge spi_clk or negedge arst_n)
   begin
      if (!arst_n)
         tx_tgl_sync_ff <= '0;
      else
         tx_tgl_sync_ff <= {tx_tgl_sync_ff[0], tx_tgl_ff};
   end

   // A byte not refreshed since the last load goes out as all ones.
   assign tx_src = (tx_tgl_sync_ff[1] != tx_used_ff) ? tx_hold_ff : SFPI_UNDERRUN_BYTE;
   assign tx_cur = (tx_cnt_ff == SFPI_CNT_RST) ? tx_src : tx_shift_ff;

   always_comb
   begin
      case (eff_w)
         SFPI_LANE_DUAL: oe_want = 4'h3;
         SFPI_LANE_QUAD: oe_want = 4'hf;
         default: oe_want = 4'h2;
      endcase
      if (!lcfg.drive_out)
         oe_want = 4'h0;
   end

   // The load marker survives deselect, so a byte handed over before the frame still goes out.
   always_ff @(negedge spi_clk or negedge arst_n)
   begin
      if (!arst_n)
         tx_used_ff <= 1'b0;
      else if (link_rst_n && !(hold_fn && !lane_in[3]) && tx_cnt_ff == SFPI_CNT_RST
         && lcfg.drive_out)
         tx_used_ff <= tx_tgl_sync_ff[1];
   end

   // Falling edge drive; an edge that enters hold is not taken.
   always_ff @(negedge spi_clk or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         tx_shift_ff <= SFPI_BYTE_RST;
         tx_cnt_ff <= SFPI_CNT_RST;
         out_ff <= 4'h0;
         oe_ff <= 4'h0;
      end
      else if (!(hold_fn && !lane_in[3]))
      begin
         oe_ff <= oe_want;
         case (eff_w)
            SFPI_LANE_DUAL:
            begin
               out_ff <= {2'b00, tx_cur[7:6]};
               tx_shift_ff <= {tx_cur[5:0], 2'b00};
            end
            SFPI_LANE_QUAD:
            begin
               out_ff <= tx_cur[7:4];
               tx_shift_ff <= {tx_cur[3:0], 4'h0};
            end
            default:
            begin
               out_ff <= {2'b00, tx_cur[7], 1'b0};
               tx_shift_ff <= {tx_cur[6:0], 1'b0};
            end
         endcase
         if (!lcfg.drive_out || tx_cnt_ff == sfpi_last_cnt(eff_w))
            tx_cnt_ff <= SFPI_CNT_RST;
         else
            tx_cnt_ff <= tx_cnt_ff + 3'h1;
      end
   end

   // Hold floats the lanes at once while the clock is low, else at the next fall; select high clears the enables through reset.
   assign pins_out = {out_ff, (hold_act ? 4'h0 : oe_ff)};

   // ---------------- ref_clk side: byte delivery ----------------
   logic [SFPI_SYNC_STAGES:0] rx_tgl_sync_ff;
   logic rx_valid_ff;
   logic [7:0] rx_data_ff;
   logic rx_instr_ff;

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         rx_tgl_sync_ff <= '0;
      else
         rx_tgl_sync_ff <= {rx_tgl_sync_ff[1:0], rx_tgl_ff};
   end

   // armed_ff is set on the first edge after reset, so no byte is dropped for want of a select edge.
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rx_valid_ff <= 1'b0;
         rx_data_ff <= SFPI_BYTE_RST;
         rx_instr_ff <= 1'b0;
      end
      else
      begin
         rx_valid_ff <= armed_ff && (rx_tgl_sync_ff[2] != rx_tgl_sync_ff[1]);
         if (rx_tgl_sync_ff[2] != rx_tgl_sync_ff[1])
         begin
            rx_data_ff <= rx_byte_ff;
            rx_instr_ff <= rx_byte_instr_ff;
         end
      end
   end

   assign rx_valid = rx_valid_ff;
   assign rx_data = rx_data_ff;
   assign rx_instr = rx_instr_ff;

   // ---------------- ref_clk side: array geometry ----------------
   sfpi_geom_t geom_ff;
   logic [15:0] erase_first_ff;
   logic [16:0] erase_pages_ff;
   logic [7:0] prog_result_ff;

   // Indices are address slices, so every unit is aligned on its own size.
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         geom_ff <= '0;
      else
      begin
         geom_ff.page <= geo_addr[SFPI_ADDR_W-1:SFPI_PAGE_LSB];
         geom_ff.offset <= geo_addr[SFPI_PAGE_LSB-1:0];
         geom_ff.sector <= geo_addr[SFPI_ADDR_W-1:SFPI_SECTOR_LSB];
         geom_ff.blk32 <= geo_addr[SFPI_ADDR_W-1:SFPI_BLK32_LSB];
         geom_ff.blk64 <= geo_addr[SFPI_ADDR_W-1:SFPI_BLK64_LSB];
      end
   end

   // Erase span: first page rounded down to the unit, and the page count.
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         erase_first_ff <= 16'h0000;
         erase_pages_ff <= 17'h00000;
      end
      else
      begin
         case (erase_kind)
            SFPI_ERASE_SECTOR:
            begin
               erase_first_ff <= {geo_addr[23:12], 4'h0};
               erase_pages_ff <= SFPI_PAGES_SECTOR;
            end
            SFPI_ERASE_BLK32:
            begin
               erase_first_ff <= {geo_addr[23:15], 7'h00};
               erase_pages_ff <= SFPI_PAGES_BLK32;
            end
            SFPI_ERASE_BLK64:
            begin
               erase_first_ff <= {geo_addr[23:16], 8'h00};
               erase_pages_ff <= SFPI_PAGES_BLK64;
            end
            SFPI_ERASE_CHIP:
            begin
               erase_first_ff <= 16'h0000;
               erase_pages_ff <= SFPI_PAGES_CHIP;
            end
            default:
            begin
               erase_first_ff <= 16'h0000;
               erase_pages_ff <= 17'h00000;
            end
         endcase
      end
   end

   // Programming can only clear bits; ones come back only by erase.
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         prog_result_ff <= SFPI_UNDERRUN_BYTE;
      else
         prog_result_ff <= prog_old & prog_new;
   end

   assign geom = geom_ff;
   assign erase_first_page = erase_first_ff;
   assign erase_pages = erase_pages_ff;
   assign prog_result = prog_result_ff;
endmodule
`default_nettype wire

// [design/sfpi_pkg.sv]
// Constants, enumerations and carriers for the serial flash pin interface.
// Assumes a core that owns the status bits and the array behind this block.
package sfpi_pkg;
   // Array organisation.
   localparam int SFPI_ADDR_W = 24;
   localparam int SFPI_PAGE_BYTES = 256;
   localparam int SFPI_PAGES = 65536;
   localparam int SFPI_SECTORS = 4096;
   localparam int SFPI_BLK32S = 512;
   localparam int SFPI_BLK64S = 256;
   localparam int SFPI_PAGE_LSB = 8;
   localparam int SFPI_SECTOR_LSB = 12;
   localparam int SFPI_BLK32_LSB = 15;
   localparam int SFPI_BLK64_LSB = 16;
   localparam logic [16:0] SFPI_PAGES_SECTOR = 17'h00010;
   localparam logic [16:0] SFPI_PAGES_BLK32 = 17'h00080;
   localparam logic [16:0] SFPI_PAGES_BLK64 = 17'h00100;
   localparam logic [16:0] SFPI_PAGES_CHIP = 17'h10000;
   // Reset values and fillers.
   localparam logic [7:0] SFPI_BYTE_RST = 8'h00;
   localparam logic [7:0] SFPI_UNDERRUN_BYTE = 8'hff;
   localparam logic [2:0] SFPI_CNT_RST = 3'h0;
   localparam int SFPI_SYNC_STAGES = 2;

   typedef enum logic [1:0]
   {
      SFPI_LANE_SINGLE = 2'b00,
      SFPI_LANE_DUAL = 2'b01,
      SFPI_LANE_QUAD = 2'b10
   } sfpi_lane_t;

   typedef enum logic [2:0]
   {
      SFPI_ERASE_NONE = 3'b000,
      SFPI_ERASE_SECTOR = 3'b001,
      SFPI_ERASE_BLK32 = 3'b010,
      SFPI_ERASE_BLK64 = 3'b011,
      SFPI_ERASE_CHIP = 3'b100
   } sfpi_erase_t;

   typedef enum logic
   {
      SFPI_PH_INSTR = 1'b0,
      SFPI_PH_BODY = 1'b1
   } sfpi_phase_t;

   // Configuration from the core's status bits, level signals.
   typedef struct packed
   {
      logic quad_enable;
      logic hold_reset_select;
      logic four_wire_instruction_mode;
      sfpi_lane_t lane;
      logic drive_out;
   } sfpi_cfg_t;

   typedef struct packed
   {
      logic [15:0] page;
      logic [7:0] offset;
      logic [11:0] sector;
      logic [8:0] blk32;
      logic [7:0] blk64;
   } sfpi_geom_t;

   typedef struct packed
   {
      logic [3:0] lane_out;
      logic [3:0] lane_oe;
   } sfpi_pins_out_t;
endpackage

// [tb/sfpi_checker.sv]
// Concurrent checks on the ports of sfpi_top.
// Assumes it is bound to sfpi_top; every check runs on ref_clk with arst_n.
`timescale 1ns/1ps
`default_nettype none
module sfpi_checker
   import sfpi_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic spi_clk,
   input wire logic cs_n,
   input wire logic [3:0] lane_in,
   input wire sfpi_pkg::sfpi_pins_out_t pins_out,
   input wire sfpi_pkg::sfpi_cfg_t cfg,
   input wire logic rx_valid,
   input wire logic rx_instr,
   input wire logic status_write_blocked,
   input wire logic hw_reset_req,
   input wire logic selected,
   input wire logic [SFPI_ADDR_W-1:0] geo_addr,
   input wire sfpi_pkg::sfpi_erase_t erase_kind,
   input wire logic [7:0] prog_old,
   input wire logic [7:0] prog_new,
   input wire sfpi_pkg::sfpi_geom_t geom,
   input wire logic [15:0] erase_first_page,
   input wire logic [16:0] erase_pages,
   input wire logic [7:0] prog_result
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   // Registered outputs lag one edge, so each looks back and skips the edge after reset.
   a_geom_fields:
   assert property ($past(arst_n) |-> geom == {$past(geo_addr[23:8]), $past(geo_addr[7:0]),
      $past(geo_addr[23:12]), $past(geo_addr[23:15]), $past(geo_addr[23:16])})
      else $error("geometry fields do not follow the address");
   a_erase_sector:
   assert property ($past(arst_n) && $past(erase_kind) == SFPI_ERASE_SECTOR |->
      erase_pages == 17'h00010 && erase_first_page == {$past(geo_addr[23:12]), 4'h0})
      else $error("sector erase range wrong");
   a_erase_blk64:
   assert property ($past(arst_n) && $past(erase_kind) == SFPI_ERASE_BLK64 |->
      erase_pages == 17'h00100 && erase_first_page == {$past(geo_addr[23:16]), 8'h00})
      else $error("64KB block erase range wrong");
   a_prog_clear:
   assert property ($past(arst_n) |-> prog_result == ($past(prog_old) & $past(prog_new)))
      else $error("program result sets a bit");
   a_wp_block:
   assert property ((!cfg.quad_enable && !lane_in[2]) [*8] |-> status_write_blocked)
      else $error("status write not blocked");
   a_wp_off:
   assert property (cfg.quad_enable [*8] |-> !status_write_blocked)
      else $error("write protect active in quad mode");
   a_rst_pin:
   assert property ((!cfg.quad_enable && cfg.hold_reset_select && !lane_in[3]) [*8] |->
      hw_reset_req) else $error("reset pin ignored");
   a_rst_off:
   assert property ((cfg.quad_enable || !cfg.hold_reset_select) [*8] |-> !hw_reset_req)
      else $error("reset raised while pin is not a reset pin");
   a_desel_float:
   assert property (cs_n [*4] |-> pins_out.lane_oe == 4'h0 && !selected)
      else $error("lanes driven while deselected");
   a_hold_float:
   assert property ((!cfg.quad_enable && !cfg.hold_reset_select && !cs_n && !lane_in[3]
      && !spi_clk) [*2] |-> pins_out.lane_oe == 4'h0) else $error("lanes driven in hold");
   a_rx_pulse:
   assert property (rx_valid |=> !rx_valid) else $error("byte strobe longer than a cycle");
   c_instr: cover property (rx_valid && rx_instr);
   c_wp: cover property (status_write_blocked);
   c_rst: cover property (hw_reset_req);
   c_chip: cover property (erase_kind == SFPI_ERASE_CHIP);
endmodule
bind sfpi_top sfpi_checker chk_u (.ref_clk(ref_clk), .arst_n(arst_n), .spi_clk(spi_clk),
   .cs_n(cs_n), .lane_in(lane_in), .pins_out(pins_out), .cfg(cfg), .rx_valid(rx_valid),
   .rx_instr(rx_instr), .status_write_blocked(status_write_blocked),
   .hw_reset_req(hw_reset_req), .selected(selected), .geo_addr(geo_addr),
   .erase_kind(erase_kind), .prog_old(prog_old), .prog_new(prog_new), .geom(geom),
   .erase_first_page(erase_first_page), .erase_pages(erase_pages),
   .prog_result(prog_result));
`default_nettype wire

// [tb/sfpi_host_model.sv]
// Behavioural SPI host that makes spi_clk, select and lane levels.
// Assumes the bench calls its tasks; period 15 ns, four clock pulses with select high before each frame.
`timescale 1ns/1ps
`default_nettype none
module sfpi_host_model
   import sfpi_pkg::*;
(
   output logic spi_clk,
   output logic cs_n,
   output logic [3:0] lane_in,
   input wire sfpi_pkg::sfpi_pins_out_t pins_out
);
   logic [3:0] drv;
   logic [3:0] en;
   logic [3:0] last;
   initial
   begin
      spi_clk = 1'b0;
      cs_n = 1'b1;
      drv = 4'hf;
      en = 4'hd;
      last = 4'h0;
   end
   // Device wins where it drives; lanes 2 and 3 pull up, an idle lane flips so no stale value.
   always_comb
      for (int i = 0; i < 4; i++)
         lane_in[i] = pins_out.lane_oe[i] ? pins_out.lane_out[i] : en[i] ? drv[i] :
            (i > 1) ? 1'b1 : ~last[i];
   always @(posedge spi_clk)
      last <= lane_in;
   task automatic pulses(input int n);
      repeat (n)
      begin
         #7.5 spi_clk = 1'b1;
         #7.5 spi_clk = 1'b0;
      end
   endtask
   // The odd offset keeps link edges off the core clock edges.
   task automatic open(input logic idle_hi);
      #1.3;
      pulses(4);
      spi_clk = idle_hi;
      #7.5 cs_n = 1'b0;
      #7.5;
   endtask
   task automatic close(input logic idle_hi);
      #7.5 spi_clk = idle_hi;
      #7.5 cs_n = 1'b1;
      #15;
   endtask
   // Data changes mid low phase, apart from the falling edge, and is taken back at the rise.
   task automatic clk_step(input logic [3:0] v, output logic [3:0] s);
      spi_clk = 1'b0;
      #3.75 drv = v;
      #3.75 s = lane_in;
      spi_clk = 1'b1;
      #7.5;
   endtask
   task automatic byte_x(input int w, input logic [7:0] b, output logic [7:0] r);
      logic [3:0] s;
      logic [7:0] sh;
      sh = b;
      for (int k = 0; k < 8 / w; k++)
      begin
         clk_step(w == 4 ? sh[7:4] : w == 2 ? {2'h3, sh[7:6]} : {3'h7, sh[7]}, s);
         r = {r[6:0], s[1]};
         sh = sh << w;
      end
   endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for sfpi_top with a host model on the link side.
// Assumes sfpi_pkg and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import sfpi_pkg::*;
   logic ref_clk;
   logic arst_n;
   logic spi_clk;
   logic cs_n;
   logic [3:0] lane_in;
   sfpi_pins_out_t pins_out;
   sfpi_cfg_t cfg;
   sfpi_geom_t geom;
   sfpi_erase_t erase_kind;
   logic rx_valid, rx_instr, tx_valid, swb, hwr, sel;
   logic [7:0] rx_data, tx_data, prog_old, prog_new, prog_result;
   logic [23:0] geo_addr;
   logic [15:0] first_page;
   logic [16:0] pages;
   logic [8:0] rxq[$];
   int n_mismatch, samples_checked, cycles;
   sfpi_top dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .spi_clk(spi_clk), .cs_n(cs_n),
      .lane_in(lane_in), .pins_out(pins_out), .cfg(cfg), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_instr(rx_instr), .tx_valid(tx_valid), .tx_data(tx_data),
      .status_write_blocked(swb), .hw_reset_req(hwr), .selected(sel),
      .geo_addr(geo_addr), .erase_kind(erase_kind), .prog_old(prog_old),
      .prog_new(prog_new), .geom(geom), .erase_first_page(first_page),
      .erase_pages(pages), .prog_result(prog_result));
   sfpi_host_model host_u (.spi_clk(spi_clk), .cs_n(cs_n), .lane_in(lane_in),
      .pins_out(pins_out));
   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // Received bytes queue up so that a scenario may read them after the frame.
   always @(posedge ref_clk)
   begin
      cycles <= cycles + 1;
      if (rx_valid === 1'b1)
         rxq.push_back({rx_instr, rx_data});
      if (cycles == 20000)
      begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic get_rx(output logic [8:0] v);
      for (int i = 0; i < 40 && rxq.size() == 0; i++)
         @(posedge ref_clk);
      v = rxq.size() != 0 ? rxq.pop_front() : 9'hx;
   endtask
   task automatic set_cfg(input logic [5:0] c);
      @(posedge ref_clk);
      cfg <= sfpi_cfg_t'(c);
      repeat (8) @(posedge ref_clk);
   endtask
   task automatic t_status();
      host_u.drv = 4'h3;
      set_cfg(6'h10);
      chk(swb, 1'b1);
      chk(hwr, 1'b1);
      set_cfg(6'h00);
      chk(hwr, 1'b0);
      set_cfg(6'h30);
      chk({swb, hwr}, 2'h0);
      host_u.drv = 4'hf;
      set_cfg(6'h00);
      chk(swb, 1'b0);
   endtask
   task automatic t_geom();
      logic [23:0] a [4] = '{24'hfff000, 24'hf8f000, 24'h08f000, 24'h01f000};
      logic [28:0] e [4] = '{{12'hfff, 9'h1ff, 8'hff}, {12'hf8f, 9'h1f1, 8'hf8},
         {12'h08f, 9'h011, 8'h08}, {12'h01f, 9'h003, 8'h01}};
      sfpi_erase_t k [5] = '{SFPI_ERASE_NONE, SFPI_ERASE_SECTOR, SFPI_ERASE_BLK32,
         SFPI_ERASE_BLK64, SFPI_ERASE_CHIP};
      logic [16:0] np [5] = '{17'h0, 17'h10, 17'h80, 17'h100, 17'h10000};
      logic [15:0] fp [5] = '{16'h0, 16'habc0, 16'hab80, 16'hab00, 16'h0};
      logic [7:0] po [4] = '{8'hf0, 8'hff, 8'h5a, 8'h0f};
      logic [7:0] pn [4] = '{8'h3c, 8'h81, 8'hff, 8'hf0};
      logic [7:0] pr [4] = '{8'h30, 8'h81, 8'h5a, 8'h00};
      for (int i = 0; i < 4; i++)
      begin
         @(posedge ref_clk);
         geo_addr <= a[i];
         prog_old <= po[i];
         prog_new <= pn[i];
         @(posedge ref_clk);
         @(negedge ref_clk);
         chk({geom.sector, geom.blk32, geom.blk64}, e[i]);
         chk({geom.page, geom.offset}, a[i]);
         chk(prog_result, pr[i]);
      end
      for (int i = 0; i < 5; i++)
      begin
         @(posedge ref_clk);
         geo_addr <= 24'habcdef;
         erase_kind <= k[i];
         @(posedge ref_clk);
         @(negedge ref_clk);
         chk(pages, np[i]);
         chk(first_page, fp[i]);
      end
   endtask
   task automatic t_quad();
      logic [7:0] r;
      logic [8:0] v;
      set_cfg(6'h2a); // quad_enable is set before any quad transfer
      host_u.en = 4'hf;
      host_u.open(1'b0);
      host_u.byte_x(4, 8'hc3, r);
      host_u.byte_x(2, 8'h5a, r);
      host_u.close(1'b0);
      get_rx(v);
      chk(v, 9'h1c3);
      get_rx(v);
      chk(v, 9'h05a);
      set_cfg(6'h04);
      host_u.en = 4'hd;
      host_u.open(1'b0);
      host_u.byte_x(1, 8'ha5, r);
      host_u.close(1'b0);
      get_rx(v);
      chk(v, 9'h1a5);
   endtask
   task automatic t_tx(input logic [7:0] b);
      logic [7:0] r;
      set_cfg(6'h01);
      tx_valid <= 1'b1;
      tx_data <= b;
      @(posedge ref_clk);
      tx_valid <= 1'b0;
      host_u.open(1'b1);
      host_u.byte_x(1, 8'h00, r);
      chk(r, b);
      chk(sel, 1'b1);
      host_u.byte_x(1, 8'h00, r);
      chk(r, 8'hff);
      host_u.close(1'b1);
      repeat (6) @(posedge ref_clk);
      chk(pins_out.lane_oe, 4'h0);
      chk(sel, 1'b0);
      rxq.delete();
      set_cfg(6'h00);
   endtask
   // Four edges are clocked while lane 3 is low; only quad_enable decides whether they count.
   task automatic t_hold(input logic qe);
      logic [3:0] s;
      logic [8:0] v;
      logic [11:0] hb;
      hb = 12'h9f6;
      set_cfg({qe, 5'h00});
      host_u.open(1'b0);
      for (int i = 0; i < 12; i++)
         host_u.clk_step({i < 4 || i > 7, 2'h3, hb[11 - i]}, s);
      host_u.close(1'b0);
      get_rx(v);
      chk(v, {1'b1, qe ? 8'h9f : 8'h96});
      repeat (10) @(posedge ref_clk);
      chk(rxq.size(), 0);
   endtask
   task automatic tally_and_finish();
      if (n_mismatch == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      arst_n = 1'b0;
      cfg = '0;
      tx_valid = 1'b0;
      tx_data = 8'h00;
      geo_addr = 24'h000000;
      erase_kind = SFPI_ERASE_NONE;
      prog_old = 8'h00;
      prog_new = 8'h00;
      n_mismatch = 0;
      samples_checked = 0;
      cycles = 0;
      host_u.pulses(2);
      repeat (3) @(posedge ref_clk);
      arst_n <= 1'b1;
      t_status();
      t_geom();
      t_quad();
      t_tx(8'h3c);
      t_hold(1'b0);
      t_hold(1'b1);
      tally_and_finish();
   end
endmodule
`default_nettype wire
